// ---- core/gated_counter.sv ----
/*
 * Real-time counter that advances only while its gate is high.
 * Assumes gate is a registered level.
 */
`timescale 1ns/10ps
module gated_counter #(
    parameter int WIDTH = 8
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic gate,
    output logic [WIDTH-1:0] count_reg
);
    // ****************************************************************
    // Counter
    // ****************************************************************
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            count_reg <= '0;
        end else if (clk_en && gate) begin
            count_reg <= count_reg + 1'b1;
        end
    end
endmodule

// ---- core/rom_fetch.sv ----
/*
 * External program ROM fetch and program paging block.
 * Assumes an external ROM that answers within the access time, straps synchronous
 * to sys_clk, and an Avalon-MM master for the registers.
 */
// The implementer's own choices: the address map and the Avalon-MM register port.
// Behaviour
// - Wide strap high reads 13 data lines, low reads only eight lines
// - Narrow mode: half select low fetches high 5 bits, high fetches low 8
// - Drive program address for each fetch; ROM returns word on data bus
// - Pulse instruction done strobe when instruction complete, next may fetch
// - Drive even/odd ROM select to choose one of two ROM banks
// - Page strap low: 4-bit page in bits 3..0, port bits 7..4 above
// - Page strap high: 5-bit page in bits 4..0, port bits 7..5 above
// - Page field value is the program page number directly
// - Page changes by page instruction or by long jump and long call
// - Real-time counter counts while gate high, holds while low
// - Main clock rate chosen by clock-rate select input level
// - Tone tolerance narrow when select low, wide when high
// - Supply detector enabled while its active-low enable is low
// - Analog power bit 5 powers stutter tone detector up or down
// - Both upper port seven interrupt inputs set one shared flag
// - Wake-capable bank pins may be configured as watchdog wake sources
// - Test input high enters test mode; normally low
`timescale 1ns/10ps
module rom_fetch #(
    parameter int TIMER_W = 8
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic rom_bus_width_strap,
    input wire logic page_width_strap,
    input wire logic timer_count_gate,
    input wire logic clock_rate_select,
    input wire logic tone_tolerance_select,
    input wire logic supply_detector_enable_n,
    input wire logic test_mode_in,
    input wire logic ext_irq_two,
    input wire logic ext_irq_three,
    input wire logic [7:0] wake_capable_io_bank,
    input wire logic [12:0] program_data_bus,
    output logic [14:0] program_address_bus,
    output logic byte_half_select,
    output logic even_odd_rom_select,
    output logic instruction_done_strobe,
    output logic [7:0] upper_io_bits,
    output logic stutter_tone_detector_power,
    output logic slow_clock_select,
    output logic wide_tone_tolerance,
    output logic supply_detector_on,
    output logic test_mode,
    output logic shared_irq_flag,
    output logic wake_request,
    output logic [12:0] instruction_word
);
    // ****************************************************************
    // Declarations
    // ****************************************************************
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_HIGH = 5'b00010,
        ST_LOW = 5'b00100,
        ST_DONE = 5'b01000,
        ST_NEXT = 5'b10000
    } fetch_state_t;
    fetch_state_t state_reg;
    logic wide_bus_reg;
    logic wide_page_reg;
    logic gate_reg;
    logic [7:0] page_select_reg;
    logic [7:0] analog_power_reg;
    logic [7:0] wake_enable_reg;
    logic [9:0] pc_reg;
    logic [4:0] fetch_page_reg;
    logic [7:0] wait_reg;
    logic [12:0] word_reg;
    logic run_reg;
    logic [9:0] jump_target_reg;
    logic long_pending_reg;
    logic irq_two_prev;
    logic irq_three_prev;
    logic [TIMER_W-1:0] timer_count;
    logic [4:0] page_field;
    logic bus_access;
    logic irq_event;
    logic clear_irq;
    logic [12:0] word_next;
    // ****************************************************************
    // Strap sampling
    // ****************************************************************
    strap_sampler #(.RESET_VAL(1'b1)) u_bus_strap (
        .sys_clk(sys_clk),
        .rst(rst),
        .clk_en(clk_en),
        .level_in(rom_bus_width_strap),
        .level_reg(wide_bus_reg)
    );
    strap_sampler #(.RESET_VAL(1'b0)) u_page_strap (
        .sys_clk(sys_clk),
        .rst(rst),
        .clk_en(clk_en),
        .level_in(page_width_strap),
        .level_reg(wide_page_reg)
    );
    strap_sampler #(.RESET_VAL(1'b1)) u_gate (
        .sys_clk(sys_clk),
        .rst(rst),
        .clk_en(clk_en),
        .level_in(timer_count_gate),
        .level_reg(gate_reg)
    );
    gated_counter #(.WIDTH(TIMER_W)) u_timer (
        .sys_clk(sys_clk),
        .rst(rst),
        .clk_en(clk_en),
        .gate(gate_reg),
        .count_reg(timer_count)
    );
    // ****************************************************************
    // Misc strap outputs
    // ****************************************************************
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            slow_clock_select <= 1'b0;
            wide_tone_tolerance <= 1'b0;
            supply_detector_on <= 1'b0;
            test_mode <= 1'b0;
        end else if (clk_en) begin
            slow_clock_select <= clock_rate_select;
            wide_tone_tolerance <= tone_tolerance_select;
            supply_detector_on <= ~supply_detector_enable_n;
            test_mode <= test_mode_in;
        end
    end
    // ****************************************************************
    // Register bus
    // ****************************************************************
    assign bus_access = (avs_read || avs_write) && avs_waitrequest;
    assign clear_irq = avs_write && !avs_waitrequest && avs_address == rom_fetch_pkg::OFS_STATUS
        && avs_writedata[0];
    assign page_field = wide_page_reg ? page_select_reg[4:0] : {1'b0, page_select_reg[3:0]};
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
        end else if (clk_en) begin
            avs_waitrequest <= !bus_access;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            avs_readdata <= 32'h00000000;
        end else if (clk_en && bus_access && avs_read) begin
            case (avs_address)
                rom_fetch_pkg::OFS_PAGE_SELECT: avs_readdata <= {24'h000000, page_select_reg};
                rom_fetch_pkg::OFS_ANALOG_POWER: avs_readdata <= {24'h000000, analog_power_reg};
                rom_fetch_pkg::OFS_FETCH_CTRL: avs_readdata <= {16'h0000, wake_enable_reg, 5'h00, run_reg,
                    2'h0};
                rom_fetch_pkg::OFS_STATUS: avs_readdata <= {3'h0, word_reg, 8'(timer_count),
                    1'b0, page_field, wide_bus_reg, shared_irq_flag};
                default: avs_readdata <= 32'h00000000;
            endcase
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            page_select_reg <= rom_fetch_pkg::PAGE_SELECT_RESET;
            long_pending_reg <= 1'b0;
            jump_target_reg <= 10'h000;
        end else if (clk_en) begin
            if ((state_reg == ST_IDLE && run_reg) || (state_reg == ST_NEXT && wait_reg <= 8'h01)) begin
                long_pending_reg <= 1'b0;
            end
            if (avs_write && !avs_waitrequest && avs_address == rom_fetch_pkg::OFS_PAGE_SELECT) begin
                page_select_reg <= avs_writedata[7:0];
            end else if (avs_write && !avs_waitrequest && avs_address == rom_fetch_pkg::OFS_FETCH_CTRL
                && avs_writedata[rom_fetch_pkg::CTRL_LONG_BIT]) begin
                // Long jump or call sets page
                if (wide_page_reg) begin
                    page_select_reg[4:0] <= avs_writedata[20:16];
                end else begin
                    page_select_reg[3:0] <= avs_writedata[19:16];
                end
                jump_target_reg <= avs_writedata[31:22];
                long_pending_reg <= 1'b1;
            end
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            analog_power_reg <= rom_fetch_pkg::ANALOG_POWER_RESET;
            wake_enable_reg <= 8'h00;
            run_reg <= 1'b0;
        end else if (clk_en && avs_write && !avs_waitrequest) begin
            if (avs_address == rom_fetch_pkg::OFS_ANALOG_POWER) begin
                analog_power_reg <= avs_writedata[7:0];
            end
            if (avs_address == rom_fetch_pkg::OFS_FETCH_CTRL) begin
                run_reg <= avs_writedata[rom_fetch_pkg::CTRL_RUN_BIT];
                wake_enable_reg <= avs_writedata[15:8];
            end
        end
    end
    // ****************************************************************
    // Port and detector outputs
    // ****************************************************************
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            upper_io_bits <= 8'h00;
            stutter_tone_detector_power <= 1'b0;
            wake_request <= 1'b0;
        end else if (clk_en) begin
            // Fewer port bits in wide layout
            upper_io_bits <= wide_page_reg ? {page_select_reg[7:5], 5'h00} : {page_select_reg[7:4], 4'h0};
            stutter_tone_detector_power <= analog_power_reg[rom_fetch_pkg::SDT_POWER_BIT];
            wake_request <= |(wake_enable_reg & wake_capable_io_bank);
        end
    end
    // ****************************************************************
    // Shared interrupt flag
    // ****************************************************************
    // Either input sets one flag
    assign irq_event = (ext_irq_two && !irq_two_prev) || (ext_irq_three && !irq_three_prev);
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq_two_prev <= 1'b0;
            irq_three_prev <= 1'b0;
            shared_irq_flag <= 1'b0;
        end else if (clk_en) begin
            irq_two_prev <= ext_irq_two;
            irq_three_prev <= ext_irq_three;
            if (irq_event) begin
                shared_irq_flag <= 1'b1;
            end else if (clear_irq) begin
                shared_irq_flag <= 1'b0;
            end
        end
    end
    // ****************************************************************
    // Fetch sequencer
    // ****************************************************************
    // Width selects data lines used
    always_comb begin
        word_next = word_reg;
        if (wide_bus_reg) begin
            word_next = program_data_bus;
        end else if (state_reg == ST_HIGH) begin
            word_next = {program_data_bus[4:0], 8'h00};
        end else begin
            word_next = {word_reg[12:8], program_data_bus[7:0]};
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            wait_reg <= 8'h00;
            word_reg <= 13'h0000;
            pc_reg <= 10'h000;
            fetch_page_reg <= 5'h00;
            byte_half_select <= 1'b0;
            instruction_done_strobe <= 1'b0;
            instruction_word <= 13'h0000;
        end else if (clk_en) begin
            case (state_reg)
                ST_IDLE: begin
                    instruction_done_strobe <= 1'b0;
                    if (run_reg) begin
                        fetch_page_reg <= page_field;
                        if (long_pending_reg) begin
                            pc_reg <= jump_target_reg;
                        end
                        byte_half_select <= 1'b0;
                        wait_reg <= rom_fetch_pkg::WAIT_INIT;
                        state_reg <= ST_HIGH;
                    end
                end
                ST_HIGH: begin
                    if (wait_reg > 8'h01) begin
                        wait_reg <= wait_reg - 8'h01;
                    end else begin
                        word_reg <= word_next;
                        if (wide_bus_reg) begin
                            state_reg <= ST_DONE;
                        end else begin
                            byte_half_select <= 1'b1;
                            wait_reg <= rom_fetch_pkg::WAIT_INIT;
                            state_reg <= ST_LOW;
                        end
                    end
                end
                ST_LOW: begin
                    if (wait_reg > 8'h01) begin
                        wait_reg <= wait_reg - 8'h01;
                    end else begin
                        word_reg <= word_next;
                        state_reg <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    instruction_word <= word_reg;
                    instruction_done_strobe <= 1'b1;
                    wait_reg <= rom_fetch_pkg::DONE_INIT;
                    state_reg <= ST_NEXT;
                end
                ST_NEXT: begin
                    if (wait_reg > 8'h01) begin
                        wait_reg <= wait_reg - 8'h01;
                    end else begin
                        instruction_done_strobe <= 1'b0;
                        pc_reg <= long_pending_reg ? jump_target_reg : pc_reg + 10'h001;
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            program_address_bus <= 15'h0000;
            even_odd_rom_select <= 1'b0;
        end else if (clk_en) begin
            program_address_bus <= {fetch_page_reg, pc_reg};
            even_odd_rom_select <= pc_reg[0];
        end
    end
    // ****************************************************************
    // Checks
    // ****************************************************************
    chk_narrow_half_low: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && state_reg == ST_LOW) |-> byte_half_select)
        else $error("half select not high in low read");
    chk_done_after_word: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(instruction_done_strobe) |-> $past(state_reg) == ST_DONE)
        else $error("done strobe without assembled word");
    chk_sdt_power: assert property (@(posedge sys_clk) disable iff (rst)
        clk_en |=> stutter_tone_detector_power == $past(analog_power_reg[rom_fetch_pkg::SDT_POWER_BIT]))
        else $error("detector power mismatch");
    chk_supply_enable: assert property (@(posedge sys_clk) disable iff (rst)
        clk_en |=> supply_detector_on == !$past(supply_detector_enable_n))
        else $error("supply detector enable wrong");
    chk_timer_hold: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && !gate_reg) |=> $stable(timer_count))
        else $error("timer moved while gated");
    chk_irq_shared: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && irq_event) |=> shared_irq_flag)
        else $error("shared flag not set");
    chk_test_mode: assert property (@(posedge sys_clk) disable iff (rst)
        clk_en |=> test_mode == $past(test_mode_in))
        else $error("test mode not followed");
    chk_page_stable: assert property (@(posedge sys_clk) disable iff (rst)
        (state_reg == ST_LOW) |-> $stable(fetch_page_reg))
        else $error("page changed mid fetch");
    cov_narrow: cover property (@(posedge sys_clk) state_reg == ST_LOW);
    cov_wide: cover property (@(posedge sys_clk) wide_bus_reg && instruction_done_strobe);
    cov_long: cover property (@(posedge sys_clk) long_pending_reg && state_reg == ST_NEXT);
endmodule

// ---- core/rom_fetch_pkg.sv ----
/*
 * Package of constants for the external program ROM fetch and paging block:
 * register offsets, field positions, reset values, fetch timing counts.
 * Assumes a 50 MHz system clock and 32-bit Avalon-MM register access.
 */
package rom_fetch_pkg;
    // ****************************************************************
    // Register map (byte addresses)
    // ****************************************************************
    localparam logic [3:0] OFS_PAGE_SELECT = 4'h0;
    localparam logic [3:0] OFS_ANALOG_POWER = 4'h4;
    localparam logic [3:0] OFS_FETCH_CTRL = 4'h8;
    localparam logic [3:0] OFS_STATUS = 4'hc;
    localparam logic [3:0] OFS_TIMER = 4'h0;
    // ****************************************************************
    // Field positions and reset values
    // ****************************************************************
    localparam int SDT_POWER_BIT = 5;
    localparam int NARROW_PAGE_W = 4;
    localparam int WIDE_PAGE_W = 5;
    localparam int CTRL_PAGE_INSTR_BIT = 0;
    localparam int CTRL_LONG_BIT = 1;
    localparam int CTRL_RUN_BIT = 2;
    localparam logic [7:0] PAGE_SELECT_RESET = 8'h00;
    localparam logic [7:0] ANALOG_POWER_RESET = 8'h00;
    // ****************************************************************
    // Fetch timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 20;
    localparam int ROM_ACCESS_NS = 100;
    localparam int ROM_SETUP_NS = 20;
    localparam int INSTR_DONE_WIDTH_NS = 30;
    // Least times round up
    localparam int ACCESS_CYCLES = (ROM_ACCESS_NS + ROM_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DONE_CYCLES = (INSTR_DONE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] WAIT_INIT = 8'(ACCESS_CYCLES);
    localparam logic [7:0] DONE_INIT = 8'(DONE_CYCLES);
    localparam int PROG_ADDR_W = 15;
    localparam int PROG_DATA_W = 13;
    localparam int PAGE_OFFSET_W = 10;
endpackage

// ---- core/strap_sampler.sv ----
/*
 * Strap sampler: registers one strap/control input level each cycle.
 * Assumes the input is synchronous to sys_clk.
 */
`timescale 1ns/10ps
module strap_sampler #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic level_in,
    output logic level_reg
);
    // ****************************************************************
    // Sample register
    // ****************************************************************
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            level_reg <= RESET_VAL;
        end else if (clk_en) begin
            level_reg <= level_in;
        end
    end
endmodule

// ---- dv/ext_rom_model.sv ----
/*
 * External program ROM model: returns a word derived from the fetch address.
 * Assumes address and half select come from the fetch block's registers.
 */
`timescale 1ns/10ps
module ext_rom_model (
    input wire logic [14:0] program_address_bus,
    input wire logic byte_half_select,
    input wire logic rom_bus_width_strap,
    output logic [12:0] program_data_bus
);
    logic [12:0] word;
    // ****************************************************************
    // Data return
    // ****************************************************************
    // word per address
    assign word = program_address_bus[12:0] ^ 13'h1c3a;
    // lane choice, unused lanes carry junk
    always_comb begin
        if (rom_bus_width_strap) begin
            program_data_bus = word;
        end else if (!byte_half_select) begin
            program_data_bus = {~program_address_bus[7:0], word[12:8]};
        end else begin
            program_data_bus = {~word[12:8], word[7:0]};
        end
    end
endmodule

// ---- dv/rom_fetch_test.sv ----
/*
 * Self-checking bench for the ROM fetch and paging block.
 * Assumes the register map and fetch timing of the fetch block's package.
 */
`timescale 1ns/10ps
module rom_fetch_test;
    logic sys_clk, rst, clk_en, avs_read, avs_write, avs_waitrequest, rom_bus_width_strap, page_width_strap;
    logic timer_count_gate, clock_rate_select, tone_tolerance_select, supply_detector_enable_n, test_mode_in;
    logic ext_irq_two, ext_irq_three, byte_half_select, even_odd_rom_select, instruction_done_strobe;
    logic stutter_tone_detector_power, slow_clock_select, wide_tone_tolerance, supply_detector_on;
    logic test_mode, shared_irq_flag, wake_request, prev_half;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd, t0;
    logic [7:0] wake_capable_io_bank, upper_io_bits;
    logic [12:0] program_data_bus, instruction_word;
    logic [14:0] program_address_bus;
    int mismatches = 0, checked = 0, rises = 0, r0;
    rom_fetch i_dut (.sys_clk, .rst, .clk_en, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest, .rom_bus_width_strap, .page_width_strap, .timer_count_gate,
        .clock_rate_select, .tone_tolerance_select, .supply_detector_enable_n, .test_mode_in, .ext_irq_two,
        .ext_irq_three, .wake_capable_io_bank, .program_data_bus, .program_address_bus, .byte_half_select,
        .even_odd_rom_select, .instruction_done_strobe, .upper_io_bits, .stutter_tone_detector_power,
        .slow_clock_select, .wide_tone_tolerance, .supply_detector_on, .test_mode, .shared_irq_flag,
        .wake_request, .instruction_word);
    ext_rom_model i_rom (.program_address_bus, .byte_half_select, .rom_bus_width_strap, .program_data_bus);
    // ****************************************************************
    // Clock, watchdog and helpers
    // ****************************************************************
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        close_out();
    end
    always @(negedge sys_clk) begin
        if (byte_half_select === 1'b1 && prev_half === 1'b0) rises++;
        prev_half <= byte_half_select;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] d);
        @(posedge sys_clk);
        avs_address <= a;
        avs_read <= !w;
        avs_write <= w;
        avs_writedata <= wd;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic fetch(input logic [14:0] a);
        do @(negedge sys_clk); while (instruction_done_strobe !== 1'b1);
        check(program_address_bus, a);
        check(instruction_word, a[12:0] ^ 13'h1c3a);
        check(even_odd_rom_select, a[0]);
        while (instruction_done_strobe === 1'b1) @(negedge sys_clk);
    endtask
    task automatic close_out();
        $display("Checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        {rst, clk_en, avs_read, avs_write, avs_address, avs_writedata} = {1'b1, 1'b1, 38'h0};
        {rom_bus_width_strap, page_width_strap, timer_count_gate, clock_rate_select} = 4'b1001;
        {tone_tolerance_select, supply_detector_enable_n, test_mode_in, ext_irq_two, ext_irq_three} = 5'b01000;
        wake_capable_io_bank = 8'h00;
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        acc(0, 4'h0, 0, rd); check(rd, 32'h0);
        acc(0, 4'h4, 0, rd); check(rd, 32'h0);
        acc(0, 4'h2, 0, rd); check(rd, 32'h0);
        acc(1, 4'h4, 32'h20, rd);
        repeat (2) @(posedge sys_clk);
        check(stutter_tone_detector_power, 1'b1);
        acc(1, 4'h4, 32'h0, rd);
        repeat (2) @(posedge sys_clk);
        check(stutter_tone_detector_power, 1'b0);
        acc(1, 4'h0, 32'h5b, rd);
        acc(0, 4'hc, 0, rd);
        check(rd[6:2], 5'h0b);
        check(upper_io_bits, 8'h50);
        page_width_strap <= 1'b1;
        acc(0, 4'hc, 0, rd);
        check(rd[6:2], 5'h1b);
        check(upper_io_bits, 8'h40);
        acc(1, 4'h8, 32'h4, rd);
        fetch({5'h1b, 10'h000});
        fetch({5'h1b, 10'h001});
        acc(1, 4'h8, 32'h0, rd);
        repeat (40) @(posedge sys_clk);
        rom_bus_width_strap <= 1'b0;
        r0 = rises;
        acc(1, 4'h8, {10'h155, 1'b0, 5'h02, 16'h0006}, rd);
        fetch({5'h02, 10'h155});
        fetch({5'h02, 10'h156});
        check(rises - r0, 2);
        acc(1, 4'h8, 32'h0, rd);
        timer_count_gate <= 1'b0;
        acc(0, 4'hc, 0, t0); acc(0, 4'hc, 0, rd); check(rd[15:8], t0[15:8]);
        timer_count_gate <= 1'b1;
        acc(0, 4'hc, 0, t0); acc(0, 4'hc, 0, rd); check(rd[15:8] != t0[15:8], 1'b1);
        for (int i = 0; i < 2; i++) begin
            {clock_rate_select, tone_tolerance_select, supply_detector_enable_n, test_mode_in} <= {4{i[0]}};
            repeat (4) @(posedge sys_clk);
            check(slow_clock_select, i[0]);
            check(wide_tone_tolerance, i[0]);
            check(supply_detector_on, !i[0]);
            check(test_mode, i[0]);
            {ext_irq_three, ext_irq_two} <= 2'(i + 1);
            repeat (3) @(posedge sys_clk);
            {ext_irq_three, ext_irq_two} <= 2'b00;
            acc(0, 4'hc, 0, rd); check(rd[0], 1'b1);
            check(shared_irq_flag, 1'b1);
            acc(1, 4'hc, 32'h1, rd); acc(0, 4'hc, 0, rd); check(rd[0], 1'b0);
        end
        acc(1, 4'h8, 32'h0400, rd);
        wake_capable_io_bank <= 8'h04;
        repeat (4) @(posedge sys_clk); check(wake_request, 1'b1);
        wake_capable_io_bank <= 8'h08;
        repeat (4) @(posedge sys_clk); check(wake_request, 1'b0);
        close_out();
    end
endmodule
